// *** hdl/asfc_frame_ctrl.sv ***
// Serial frame controller of an 8-channel 10-bit sampling converter
// Behaviour
// - Chip select fall starts frame and sample
// - Output 4-bit lead, 10-bit result, 2 pad bits, MSB first
// - Lead field may carry general pin status
// - Switch multiplexer on second serial clock fall
// - Acquire from 14th rise to next frame
// - Refresh general outputs at chip select fall
// - Capture input status at frame start, send
// - Zero on select fall, address bits on falls 1-3
// - Result MSB on 4th fall, LSB 13th
// - 16th fall releases output, ends conversion
// - Capture command bit on rising edges 1-16 of a frame
// - Per-channel high/low limits raise pin alarms
// - Alarm asserts on 12th fall of frame
// - Alarm clears on 10th fall next frame
// - Power-down bit acts at 16th fall of next frame
// - Pin three power-down input, async, low
// - Wake on select fall when both allow
// - Alarms active high; pin0 high, pin1 low
// - Pin two high selects range two
// - Each general pin individually configurable
// - Reset gives manual mode, channel zero
`timescale 1ns/10ps
`default_nettype none
module asfc_frame_ctrl #(
    parameter int NCH = asfc_pkg::ASFC_NCH,
    parameter int RES = asfc_pkg::ASFC_RES
) (
    input wire logic clk, // System clock, 50 MHz
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic cs_n, // Chip select pin, active low
    input wire logic sclk, // Serial clock pin
    input wire logic sdi, // Serial data in pin
    output logic sdo, // Serial data out
    output logic sdo_oe, // Serial data out drive enable
    input wire logic [asfc_pkg::ASFC_NPIN-1:0] gpio_i, // General pin levels
    output logic [asfc_pkg::ASFC_NPIN-1:0] gpio_o, // General pin drive values
    output logic [asfc_pkg::ASFC_NPIN-1:0] gpio_oe, // General pin drive enables
    input wire asfc_pkg::asfc_pin_cfg_t pin_cfg, // Function of each general pin
    input wire asfc_pkg::asfc_limits_t hi_limit, // High threshold per channel
    input wire asfc_pkg::asfc_limits_t lo_limit, // Low threshold per channel
    input wire logic [RES-1:0] conv_data, // Result from the converter core
    output logic [asfc_pkg::ASFC_CH_W-1:0] mux_ch, // Multiplexer channel selected
    output logic sample_strobe, // One-cycle pulse at the sampling instant
    output logic acquiring, // Acquisition phase in progress
    output logic conv_busy, // Conversion in progress
    output logic conv_done, // One-cycle pulse when conversion ends
    output logic range2, // Input range two selected
    output logic powered_down // Device in power-down
);
    import asfc_pkg::*;

    // Whole state of the controller
    typedef struct packed {
        asfc_phase_t phase;
        logic [4:0] rise_cnt;
        logic [4:0] fall_cnt;
        logic [ASFC_FRAME_BITS-1:0] out_word;
        logic sdo;
        logic sdo_oe;
        logic [ASFC_FRAME_BITS-1:0] in_shift;
        logic [ASFC_CH_W-1:0] ch_next;
        logic [ASFC_CH_W-1:0] mux_ch;
        logic [ASFC_CH_W-1:0] frame_ch;
        logic [RES-1:0] sample;
        logic range_cmd;
        logic pd_cmd;
        logic gpi_rd_cmd;
        logic [ASFC_NPIN-1:0] gpo_data;
        logic [ASFC_NPIN-1:0] gpo_pins;
        logic frame_pd;
        logic alarm_hi;
        logic alarm_lo;
        logic pd_state;
        logic pd_pin_seen;
        logic acquiring;
        logic conv_busy;
        logic conv_done;
        logic sample_strobe;
    } asfc_state_t;

    asfc_state_t s_reg;
    asfc_state_t s_next;

    logic [1:0] rst_pipe;
    logic rst_n_sync;
    logic [ASFC_NPIN+2:0] raw_in;
    logic [ASFC_NPIN+2:0] syn_q;
    logic [ASFC_NPIN+2:0] syn_rise;
    logic [ASFC_NPIN+2:0] syn_fall;
    logic cs_n_q;
    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic sdi_q;
    logic [ASFC_NPIN-1:0] gpio_q;
    logic pd_pin_func;
    logic range_pin_func;
    logic [ASFC_NPIN-1:0] gpi_status;
    logic [ASFC_LEAD_BITS-1:0] lead_field;
    logic [ASFC_FRAME_BITS-1:0] cmd_word;
    logic [4:0] rise_n;
    logic [4:0] fall_n;
    logic hi_hit;
    logic lo_hit;
    logic [RES-1:0] hi_sel;
    logic [RES-1:0] lo_sel;

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_pipe <= 2'h0;
        end
        else
        begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n_sync = rst_pipe[1];

    // Every pin input passes two flops before the frame logic sees it; chip select and the
    // power-down pin enter inverted so the zero reset of the flops matches their idle level
    assign raw_in = {~gpio_i[3], gpio_i[2:0], sdi, sclk, ~cs_n};

    asfc_sync #(
        .WIDTH(ASFC_NPIN + 3)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n_sync),
        .d(raw_in),
        .q(syn_q),
        .rise(syn_rise),
        .fall(syn_fall)
    );

    assign cs_n_q = ~syn_q[0];
    assign cs_fall = syn_rise[0];
    assign cs_rise = syn_fall[0];
    assign sdi_q = syn_q[2];
    assign gpio_q = {~syn_q[ASFC_NPIN+2], syn_q[ASFC_NPIN+1:3]};
    // Serial clock edges count only while chip select is low
    assign sclk_rise = syn_rise[1] & ~cs_n_q & ~cs_fall;
    assign sclk_fall = syn_fall[1] & ~cs_n_q & ~cs_fall;

    assign pd_pin_func = (pin_cfg.mode[3] == ASFC_PIN_FUNCTION);
    assign range_pin_func = (pin_cfg.mode[2] == ASFC_PIN_FUNCTION);

    // Status of pins configured as general inputs; others read as zero
    for (genvar p = 0; p < ASFC_NPIN; p++)
    begin : g_gpi
        assign gpi_status[p] = (pin_cfg.mode[p] == ASFC_PIN_GENERAL_INPUT) ? gpio_q[p] : 1'b0;
    end

    // Lead field: pin status while the last programming command asked for it, else address
    assign lead_field = s_reg.gpi_rd_cmd ? gpi_status : {1'b0, s_reg.mux_ch};

    // Word as it completes on this rising edge; bit 0 arrives last
    assign cmd_word = {s_reg.in_shift[ASFC_FRAME_BITS-2:0], sdi_q};

    assign rise_n = s_reg.rise_cnt + 5'h01;
    assign fall_n = s_reg.fall_cnt + 5'h01;

    // Thresholds of the channel that was sampled in this frame
    assign hi_sel = hi_limit[s_reg.frame_ch];
    assign lo_sel = lo_limit[s_reg.frame_ch];
    assign hi_hit = (s_reg.sample > hi_sel);
    assign lo_hit = (s_reg.sample < lo_sel);

    // Frame sequencing
    always_comb
    begin
        s_next = s_reg;
        s_next.sample_strobe = 1'b0;
        s_next.conv_done = 1'b0;

        // Pin power-down is held until a frame start finds the pin high again
        if (pd_pin_func && !gpio_q[3])
        begin
            s_next.pd_pin_seen = 1'b1;
        end

        if (cs_fall)
        begin
            // New frame: sample, start conversion, restart edge counts
            s_next.phase = ASFC_SHIFT;
            s_next.rise_cnt = 5'h00;
            s_next.fall_cnt = 5'h00;
            s_next.sample = conv_data;
            s_next.sample_strobe = 1'b1;
            s_next.conv_busy = 1'b1;
            s_next.acquiring = 1'b0;
            s_next.frame_ch = s_reg.mux_ch;
            s_next.frame_pd = s_reg.pd_cmd;
            s_next.gpo_pins = s_reg.gpo_data;
            // Lead field, result, then pad bits to fill twelve result bits
            s_next.out_word = {lead_field, conv_data, {ASFC_PAD_BITS{1'b0}}};
            s_next.sdo = lead_field[ASFC_LEAD_BITS-1];
            s_next.sdo_oe = 1'b1;
            // Wake needs both the command bit and the pin to allow it
            if (!s_reg.pd_cmd && !(pd_pin_func && !gpio_q[3]))
            begin
                s_next.pd_state = 1'b0;
                s_next.pd_pin_seen = 1'b0;
            end
        end
        else if (cs_rise)
        begin
            // Early release leaves the frame; output floats
            s_next.phase = ASFC_IDLE;
            s_next.sdo_oe = 1'b0;
            s_next.sdo = 1'b0;
        end
        else
        begin
            if (sclk_rise && s_reg.phase != ASFC_IDLE && s_reg.rise_cnt < ASFC_END_EDGE)
            begin
                s_next.rise_cnt = rise_n;
                s_next.in_shift = cmd_word;
                if (rise_n == ASFC_ACQ_RISE)
                begin
                    s_next.acquiring = 1'b1;
                end
                // Full command word taken on the 16th rising edge
                if (rise_n == ASFC_END_EDGE && cmd_word[ASFC_MODE_HI:ASFC_MODE_LO] == ASFC_MODE_MANUAL)
                begin
                    s_next.ch_next = cmd_word[ASFC_CH_LO+ASFC_CH_W-1:ASFC_CH_LO];
                    if (cmd_word[ASFC_PROG_EN_BIT])
                    begin
                        s_next.range_cmd = cmd_word[ASFC_RANGE_BIT];
                        s_next.pd_cmd = cmd_word[ASFC_POWERDOWN_REQUEST_BIT];
                        s_next.gpi_rd_cmd = cmd_word[ASFC_INPUT_STATUS_READ_BIT];
                        s_next.gpo_data = cmd_word[ASFC_GPO_HI:ASFC_GPO_LO];
                    end
                end
            end

            if (sclk_fall && s_reg.phase == ASFC_SHIFT)
            begin
                s_next.fall_cnt = fall_n;
                // Falls 1 to 15 step the word out, most significant first
                s_next.out_word = {s_reg.out_word[ASFC_FRAME_BITS-2:0], 1'b0};
                s_next.sdo = s_reg.out_word[ASFC_FRAME_BITS-2];
                if (fall_n == ASFC_MUX_FALL)
                begin
                    s_next.mux_ch = s_reg.ch_next;
                end
                if (fall_n == ASFC_ALARM_CLR_FALL)
                begin
                    s_next.alarm_hi = 1'b0;
                    s_next.alarm_lo = 1'b0;
                end
                if (fall_n == ASFC_ALARM_SET_FALL)
                begin
                    s_next.alarm_hi = hi_hit;
                    s_next.alarm_lo = lo_hit;
                end
                if (fall_n == ASFC_END_EDGE)
                begin
                    s_next.phase = ASFC_TAIL;
                    s_next.sdo_oe = 1'b0;
                    s_next.sdo = 1'b0;
                    s_next.conv_busy = 1'b0;
                    s_next.conv_done = 1'b1;
                    if (s_reg.frame_pd)
                    begin
                        s_next.pd_state = 1'b1;
                    end
                end
            end
        end
    end

    // Single register stage for all controller state
    always_ff @(posedge clk or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            s_reg <= '0;
            s_reg.phase <= ASFC_IDLE;
            s_reg.ch_next <= ASFC_RST_CH;
            s_reg.mux_ch <= ASFC_RST_CH;
            s_reg.frame_ch <= ASFC_RST_CH;
            s_reg.in_shift <= ASFC_RST_CMD;
            s_reg.gpo_data <= ASFC_RST_GPO;
            s_reg.gpo_pins <= ASFC_RST_GPO;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // General pins: input, output or fixed function, chosen per pin
    for (genvar p = 0; p < ASFC_NPIN; p++)
    begin : g_pin
        if (p == 0)
        begin : g_alarm_hi
            // Pin zero carries the high alarm, optionally merged with the low one
            assign gpio_o[p] = (pin_cfg.mode[p] == ASFC_PIN_FUNCTION) ?
                (s_reg.alarm_hi | (pin_cfg.alarm0_combined & s_reg.alarm_lo)) : s_reg.gpo_pins[p];
            assign gpio_oe[p] = (pin_cfg.mode[p] != ASFC_PIN_GENERAL_INPUT);
        end
        else if (p == 1)
        begin : g_alarm_lo
            assign gpio_o[p] = (pin_cfg.mode[p] == ASFC_PIN_FUNCTION) ? s_reg.alarm_lo : s_reg.gpo_pins[p];
            assign gpio_oe[p] = (pin_cfg.mode[p] != ASFC_PIN_GENERAL_INPUT);
        end
        else
        begin : g_func_in
            // Range and power-down functions are inputs, so the pin is not driven
            assign gpio_o[p] = s_reg.gpo_pins[p];
            assign gpio_oe[p] = (pin_cfg.mode[p] == ASFC_PIN_GENERAL_OUTPUT);
        end
    end

    assign sdo = s_reg.sdo;
    assign sdo_oe = s_reg.sdo_oe;
    assign mux_ch = s_reg.mux_ch;
    assign sample_strobe = s_reg.sample_strobe;
    assign acquiring = s_reg.acquiring;
    assign conv_busy = s_reg.conv_busy;
    assign conv_done = s_reg.conv_done;
    // Range pin is followed as a level while it owns the function
    assign range2 = range_pin_func ? gpio_q[2] : s_reg.range_cmd;
    // Raw pin term makes power-down immediate; it bypasses the synchroniser by design
    assign powered_down = s_reg.pd_state | s_reg.pd_pin_seen | (pd_pin_func & ~gpio_i[3]);

endmodule : asfc_frame_ctrl
`default_nettype wire

// *** hdl/asfc_pkg.sv ***
// Constants, field layouts and carrier types of the serial frame controller
package asfc_pkg;

    // Converter geometry
    localparam int ASFC_NCH = 8;
    localparam int ASFC_RES = 10;
    localparam int ASFC_CH_W = 3;
    localparam int ASFC_FRAME_BITS = 16;
    localparam int ASFC_LEAD_BITS = 4;
    localparam int ASFC_PAD_BITS = 2;
    localparam int ASFC_NPIN = 4;

    // Serial clock edge numbers within a frame, counted from chip select fall
    localparam logic [4:0] ASFC_MUX_FALL = 5'h02;
    localparam logic [4:0] ASFC_ADDR_LAST_FALL = 5'h03;
    localparam logic [4:0] ASFC_MSB_FALL = 5'h04;
    localparam logic [4:0] ASFC_ALARM_CLR_FALL = 5'h0a;
    localparam logic [4:0] ASFC_ALARM_SET_FALL = 5'h0c;
    localparam logic [4:0] ASFC_LSB_FALL = 5'h0d;
    localparam logic [4:0] ASFC_ACQ_RISE = 5'h0e;
    localparam logic [4:0] ASFC_END_EDGE = 5'h10;

    // Command word layout, manual sequencing
    localparam int ASFC_MODE_HI = 15;
    localparam int ASFC_MODE_LO = 12;
    localparam int ASFC_PROG_EN_BIT = 11;
    localparam int ASFC_CH_HI = 10;
    localparam int ASFC_CH_LO = 7;
    localparam int ASFC_RANGE_BIT = 6;
    localparam int ASFC_POWERDOWN_REQUEST_BIT = 5;
    localparam int ASFC_INPUT_STATUS_READ_BIT = 4;
    localparam int ASFC_GPO_HI = 3;
    localparam int ASFC_GPO_LO = 0;
    localparam logic [3:0] ASFC_MODE_MANUAL = 4'h1;

    // Reset values
    localparam logic [ASFC_CH_W-1:0] ASFC_RST_CH = 3'h0;
    localparam logic [15:0] ASFC_RST_CMD = 16'h1000;
    localparam logic [3:0] ASFC_RST_GPO = 4'h0;

    // Function of one general pin
    typedef enum logic [1:0]
    {
        ASFC_PIN_GENERAL_INPUT = 2'b00,
        ASFC_PIN_GENERAL_OUTPUT = 2'b01,
        ASFC_PIN_FUNCTION = 2'b10
    } asfc_pin_mode_t;

    // Pin configuration carried as one bundle
    typedef struct packed {
        asfc_pin_mode_t [ASFC_NPIN-1:0] mode;
        logic alarm0_combined;
    } asfc_pin_cfg_t;

    // Per-channel thresholds
    typedef logic [ASFC_NCH-1:0][ASFC_RES-1:0] asfc_limits_t;

    // Frame phase, Gray coded along idle -> shift -> tail
    typedef enum logic [1:0]
    {
        ASFC_IDLE = 2'b00,
        ASFC_SHIFT = 2'b01,
        ASFC_TAIL = 2'b11
    } asfc_phase_t;

endpackage : asfc_pkg

// *** hdl/asfc_sync.sv ***
// Two-flop synchroniser with edge detection on the settled copy
`timescale 1ns/10ps
`default_nettype none
module asfc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk, // System clock
    input wire logic rst_n, // Synchronised reset, active low
    input wire logic [WIDTH-1:0] d, // Asynchronous inputs
    output logic [WIDTH-1:0] q, // Synchronised level
    output logic [WIDTH-1:0] rise, // One-cycle pulse on rising edge
    output logic [WIDTH-1:0] fall // One-cycle pulse on falling edge
);
    import asfc_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
        logic [WIDTH-1:0] last;
    } asfc_sync_state_t;

    asfc_sync_state_t s_reg;
    asfc_sync_state_t s_next;

    // First stage feeds only the second stage; edges use stages two and three
    always_comb
    begin
        s_next.meta = d;
        s_next.sync = s_reg.meta;
        s_next.last = s_reg.sync;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // Edge detectors, one per bit
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_edge
        assign q[i] = s_reg.sync[i];
        assign rise[i] = s_reg.sync[i] & ~s_reg.last[i];
        assign fall[i] = ~s_reg.sync[i] & s_reg.last[i];
    end

endmodule : asfc_sync
`default_nettype wire

// *** tb/asfc_frame_ctrl_properties.sv ***
// Concurrent checks on the ports of the serial frame controller
`timescale 1ns/10ps
`default_nettype none
module asfc_frame_ctrl_properties (
    input wire logic clk, // System clock
    input wire logic rst_n, // Reset, active low
    input wire logic cs_n, // Chip select pin
    input wire logic sdo, // Serial data out
    input wire logic sdo_oe, // Serial out enable
    input wire logic [asfc_pkg::ASFC_NPIN-1:0] gpio_i, // Pin levels
    input wire logic [asfc_pkg::ASFC_NPIN-1:0] gpio_o, // Pin values
    input wire logic [asfc_pkg::ASFC_NPIN-1:0] gpio_oe, // Pin enables
    input wire asfc_pkg::asfc_pin_cfg_t pin_cfg, // Pin functions
    input wire logic [asfc_pkg::ASFC_CH_W-1:0] mux_ch, // Channel
    input wire logic sample_strobe, // Sample pulse
    input wire logic acquiring, // Acquisition level
    input wire logic conv_busy, // Conversion level
    input wire logic conv_done, // Conversion end pulse
    input wire logic range2, // Range two
    input wire logic powered_down // Power-down state
);
    import asfc_pkg::*;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Frame start and frame end as seen at the ports
    sequence s_open;
        sample_strobe && sdo_oe && conv_busy && !acquiring;
    endsequence
    sequence s_close;
        conv_done && !conv_busy && !sdo_oe;
    endsequence
    sequence s_pin2_high;
        (pin_cfg.mode[2] == ASFC_PIN_FUNCTION && gpio_i[2])[*4];
    endsequence
    property p_open;
        $fell(cs_n) |-> ##[2:5] s_open;
    endproperty
    property p_close;
        $fell(sdo_oe) |-> s_close;
    endproperty
    property p_quiet;
        !sdo_oe |-> !sdo;
    endproperty
    property p_acq_hold;
        $rose(acquiring) |-> conv_busy ##1 acquiring[*8];
    endproperty
    property p_acq_end;
        $fell(acquiring) |-> sample_strobe;
    endproperty
    property p_mux;
        $changed(mux_ch) |-> conv_busy && !acquiring;
    endproperty
    // Alarm pin moves only at the 10th or 12th fall, before acquisition
    property p_alarm;
        pin_cfg.mode[1] == ASFC_PIN_FUNCTION && $stable(pin_cfg) && $changed(gpio_o[1]) |-> conv_busy && !acquiring;
    endproperty
    property p_pd_cmd;
        $rose(powered_down) && pin_cfg.mode[3] != ASFC_PIN_FUNCTION |-> conv_done;
    endproperty
    property p_pd_pin;
        pin_cfg.mode[3] == ASFC_PIN_FUNCTION && !gpio_i[3] |-> powered_down;
    endproperty
    property p_wake;
        $fell(powered_down) |-> sample_strobe;
    endproperty
    property p_range;
        s_pin2_high |-> range2;
    endproperty
    property p_oe;
        gpio_oe[1] == (pin_cfg.mode[1] != ASFC_PIN_GENERAL_INPUT);
    endproperty
    a_open: assert property (p_open) else $error("frame did not open");
    a_close: assert property (p_close) else $error("output released off the 16th fall");
    a_quiet: assert property (p_quiet) else $error("data out not parked");
    a_acq_hold: assert property (p_acq_hold) else $error("acquisition window wrong");
    a_acq_end: assert property (p_acq_end) else $error("acquisition ended off frame start");
    a_mux: assert property (p_mux) else $error("channel switched at wrong time");
    a_alarm: assert property (p_alarm) else $error("alarm moved at wrong time");
    a_pd_cmd: assert property (p_pd_cmd) else $error("power-down off the 16th fall");
    a_pd_pin: assert property (p_pd_pin) else $error("pin power-down not immediate");
    a_wake: assert property (p_wake) else $error("wake off frame start");
    a_range: assert property (p_range) else $error("range pin ignored");
    a_oe: assert property (p_oe) else $error("pin one enable wrong");
endmodule : asfc_frame_ctrl_properties
`default_nettype wire

// *** tb/asfc_frame_ctrl_tb.sv ***
// Self-checking bench of the serial frame controller
`timescale 1ns/10ps
`default_nettype none
module asfc_frame_ctrl_tb;
    import asfc_pkg::*;
    logic clk, rst_n, cs_n, sclk, sdi, sdo, sdo_oe;
    logic [3:0] pin_drv, gpio_o, gpio_oe;
    wire logic [3:0] gpio_i;
    asfc_pin_cfg_t pin_cfg;
    asfc_limits_t hi_limit, lo_limit;
    logic [9:0] conv_data;
    logic [2:0] mux_ch;
    logic sample_strobe, acquiring, conv_busy, conv_done, range2, powered_down;
    logic [15:0] w;
    int bad_count;
    int checks;

    // Pin level is whoever drives it: the block when enabled, else the bench
    assign gpio_i = (gpio_oe & gpio_o) | (~gpio_oe & pin_drv);

    asfc_frame_ctrl dut (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo),
        .sdo_oe(sdo_oe), .gpio_i(gpio_i), .gpio_o(gpio_o), .gpio_oe(gpio_oe), .pin_cfg(pin_cfg),
        .hi_limit(hi_limit), .lo_limit(lo_limit), .conv_data(conv_data), .mux_ch(mux_ch),
        .sample_strobe(sample_strobe), .acquiring(acquiring), .conv_busy(conv_busy),
        .conv_done(conv_done), .range2(range2), .powered_down(powered_down));
    asfc_host_model host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));

    always #10 clk = ~clk;

    task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    // Settings change on an edge, then synchronisers get time to settle
    task automatic setup(input logic [7:0] m, input logic comb, input logic [9:0] d, input logic [3:0] p);
        @(posedge clk);
        pin_cfg <= asfc_pin_cfg_t'({m, comb});
        conv_data <= d;
        pin_drv <= p;
        repeat (5) @(posedge clk);
    endtask : setup

    // The host paces every link edge on the system clock
    task automatic xfer(input logic [15:0] cmd);
        host.frame(cmd, w);
    endtask : xfer

    task automatic t_channel();
        setup(8'h00, 1'b0, 10'h2a5, 4'h0);
        xfer(16'h1280);
        check("word", {4'h0, 10'h2a5, 2'b00}, w);
        check("sdo_oe", 16'h0000, sdo_oe);
        xfer(16'h1180);
        check("word", {4'h0, 10'h2a5, 2'b00}, w);
        check("mux_ch", 16'h0005, mux_ch);
        xfer(16'h1000);
        check("word", {4'h5, 10'h2a5, 2'b00}, w);
        check("mux_ch", 16'h0003, mux_ch);
        // A command outside manual mode must leave the next channel alone
        xfer(16'h2380);
        check("word", {4'h3, 10'h2a5, 2'b00}, w);
        xfer(16'h1000);
        check("mux_ch", 16'h0000, mux_ch);
        $display("t_channel done");
    endtask : t_channel

    task automatic t_gpo();
        setup(8'h55, 1'b0, 10'h000, 4'h0);
        xfer(16'h1805);
        check("gpio_o", 16'h0000, gpio_o);
        check("gpio_oe", 16'h000f, gpio_oe);
        xfer(16'h180a);
        check("gpio_o", 16'h0005, gpio_o);
        $display("t_gpo done");
    endtask : t_gpo

    task automatic t_gpi();
        setup(8'h00, 1'b0, 10'h155, 4'h6);
        xfer(16'h1810);
        check("gpio_oe", 16'h0000, gpio_oe);
        xfer(16'h1800);
        check("word", {4'h6, 10'h155, 2'b00}, w);
        xfer(16'h1000);
        check("word", {4'h0, 10'h155, 2'b00}, w);
        $display("t_gpi done");
    endtask : t_gpi

    // Limits are 200h high, 100h low; the comparison is strict
    task automatic t_alarm();
        setup(8'h0a, 1'b0, 10'h300, 4'h0);
        xfer(16'h1000);
        check("alarm", 16'h0001, gpio_o[1:0]);
        setup(8'h0a, 1'b0, 10'h050, 4'h0);
        xfer(16'h1000);
        check("alarm", 16'h0002, gpio_o[1:0]);
        setup(8'h0a, 1'b1, 10'h050, 4'h0);
        xfer(16'h1000);
        check("alarm", 16'h0003, gpio_o[1:0]);
        setup(8'h0a, 1'b1, 10'h200, 4'h0);
        xfer(16'h1000);
        check("alarm", 16'h0000, gpio_o[1:0]);
        $display("t_alarm done");
    endtask : t_alarm

    task automatic t_power();
        setup(8'h00, 1'b0, 10'h000, 4'h0);
        xfer(16'h1820);
        check("powered_down", 16'h0000, powered_down);
        xfer(16'h1800);
        check("powered_down", 16'h0001, powered_down);
        xfer(16'h1000);
        check("powered_down", 16'h0000, powered_down);
        setup(8'h80, 1'b0, 10'h000, 4'h0);
        check("powered_down", 16'h0001, powered_down);
        setup(8'h80, 1'b0, 10'h000, 4'h8);
        check("powered_down", 16'h0001, powered_down);
        xfer(16'h1000);
        check("powered_down", 16'h0000, powered_down);
        $display("t_power done");
    endtask : t_power

    task automatic t_range();
        setup(8'h20, 1'b0, 10'h000, 4'h4);
        check("range2", 16'h0001, range2);
        setup(8'h20, 1'b0, 10'h000, 4'h0);
        check("range2", 16'h0000, range2);
        setup(8'h00, 1'b0, 10'h000, 4'h0);
        xfer(16'h1840);
        check("range2", 16'h0001, range2);
        $display("t_range done");
    endtask : t_range

    task automatic results();
        $display("Checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results

    // About 20 frames of 3 us each; the limit leaves wide margin
    initial
    begin
        #200us;
        bad_count++;
        results();
    end

    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        pin_drv = 4'h0;
        pin_cfg = '0;
        hi_limit = {8{10'h200}};
        lo_limit = {8{10'h100}};
        conv_data = 10'h000;
        bad_count = 0;
        checks = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        check("mux_ch", 16'h0000, mux_ch);
        check("sdo_oe", 16'h0000, sdo_oe);
        t_channel();
        t_gpo();
        t_gpi();
        t_alarm();
        t_power();
        t_range();
        results();
    end
endmodule : asfc_frame_ctrl_tb

bind asfc_frame_ctrl asfc_frame_ctrl_properties u_props (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sdo(sdo),
    .sdo_oe(sdo_oe), .gpio_i(gpio_i), .gpio_o(gpio_o), .gpio_oe(gpio_oe), .pin_cfg(pin_cfg), .mux_ch(mux_ch),
    .sample_strobe(sample_strobe), .acquiring(acquiring), .conv_busy(conv_busy), .conv_done(conv_done),
    .range2(range2), .powered_down(powered_down));
`default_nettype wire

// *** tb/asfc_host_model.sv ***
// Host model that drives whole serial frames and collects the returned word
`timescale 1ns/10ps
`default_nettype none
module asfc_host_model (
    input wire logic clk, // Bench clock that paces the link
    output logic cs_n, // Chip select, active low
    output logic sclk, // Serial clock, still between frames
    output logic sdi, // Command bits
    input wire logic sdo, // Returned bits
    input wire logic sdo_oe // Return drive enable
);
    // Serial clock half period in system clocks, giving a 160 ns link period
    localparam int HALF = 4;

    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b1;
    end

    // Bits are read just before the fall that moves them on, so slow answers still pass
    task automatic frame(input logic [15:0] cmd, output logic [15:0] word);
        word = 16'h0000;
        @(posedge clk);
        cs_n <= 1'b0;
        sdi <= cmd[15];
        repeat (2 * HALF) @(posedge clk);
        for (int i = 15; i >= 0; i--)
        begin
            sclk <= 1'b1;
            repeat (HALF) @(posedge clk);
            word[i] = sdo;
            sclk <= 1'b0;
            sdi <= (i > 0) ? cmd[i - 1] : ~cmd[0];
            repeat (HALF) @(posedge clk);
        end
        cs_n <= 1'b1;
        repeat (2 * HALF) @(posedge clk);
    endtask : frame
endmodule : asfc_host_model
`default_nettype wire
